// ===== pil_cpu_model.sv
// Purpose: cpu sequencer model that accepts offered interrupts and returns
// Assumes: drives its strobes just after the falling edge of ref_clk
// Notes:   lag gives a slow answer; accept only while an offer stands
`timescale 1ns/10ps
module pil_cpu_model (
  // clock
  input  wire logic             ref_clk,
  // offer from the unit
  input  wire logic             int_pending,
  input  wire pil_pkg::pil_id_t int_id,
  input  wire logic [15:0]      int_vector,
  // strobes to the unit
  output logic                  int_accept,
  output logic                  return_from_int_instr
);
  initial begin
    int_accept            = 1'b0;
    return_from_int_instr = 1'b0;
  end

  // accept the offer standing after lag cycles
  task automatic take(input int lag, output logic [15:0] vec);
    repeat (lag) @(negedge ref_clk);
    vec = int_vector;
    int_accept = int_pending;
    @(negedge ref_clk);
    int_accept = 1'b0;
  endtask : take

  // leave the service routine
  task automatic give_back();
    @(negedge ref_clk);
    return_from_int_instr = 1'b1;
    @(negedge ref_clk);
    return_from_int_instr = 1'b0;
  endtask : give_back
endmodule : pil_cpu_model

// ===== pil_enc_if.sv
// Purpose: carrier between the latch unit and its priority encoder
// Assumes: purely combinational path
// Notes:   bit n of req is the effective request of id n
`timescale 1ns/10ps
interface pil_enc_if;
  logic [15:0]      req;
  logic             valid;
  pil_pkg::pil_id_t id;
  logic [15:0]      vector;

  modport ctrl (output req, input valid, input id, input vector);
  modport enc  (input req, output valid, output id, output vector);
endinterface : pil_enc_if

// ===== pil_latch_unit.sv
// Purpose: pending latches, enables, source select and offer of interrupts to the CPU
// Assumes: byte register port sampled on ref_clk; request inputs synchronous one-cycle pulses
// Notes:   read data one cycle after the address; offer registered
`timescale 1ns/10ps
module pil_latch_unit #(
  parameter int STACK_DEPTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             srst,
  // register port
  input  wire logic [7:0]       sfr_addr,
  input  wire logic             sfr_wr,
  input  wire logic [7:0]       sfr_wdata,
  output logic      [7:0]       sfr_rdata,
  // interrupt sources
  input  wire logic             soft_trap_request,
  input  wire logic             bad_opcode_trap,
  input  wire logic             fetch_trap_req,
  input  wire logic             guard_expiry_req,
  input  wire logic [15:4]      src_int_req,
  input  wire logic [4:0]       src_alt_req,
  input  wire logic             ext0_pin_enable,
  // cpu sequencer
  input  wire logic             int_accept,
  input  wire logic             return_from_int_instr,
  output logic                  int_pending,
  output pil_pkg::pil_id_t      int_id,
  output logic      [15:0]      int_vector,
  // reset requests
  output logic                  trap_reset_req,
  output logic                  guard_reset_req
);

  logic [15:0]            pending_latch;
  logic [15:0]            next_pending_latch;
  logic [15:0]            level_int_enable;
  logic                   master_int_enable;
  logic [7:0]             shared_level_select;
  logic                   trap_action_select;
  logic                   guard_action_select;
  logic [STACK_DEPTH-1:0] master_save_stack;
  logic [15:0]            set_vec;
  logic [15:0]            eff_req;
  logic                   accept_now;
  logic                   wr_pend_low;
  logic                   wr_pend_high;
  pil_pkg::pil_id_t       accepted_id;
  logic                   nmi_seen;
  logic [15:0]            enabled_seen;

  pil_enc_if enc_bus ();

  pil_prio_enc u_enc (
    .enc (enc_bus.enc)
  );

  assign accept_now   = int_accept && int_pending;
  assign wr_pend_low  = sfr_wr && (sfr_addr == pil_pkg::ADDR_PEND_LOW);
  assign wr_pend_high = sfr_wr && (sfr_addr == pil_pkg::ADDR_PEND_HIGH);

  // hardware set requests per level
  always_comb begin
    set_vec = 16'h0000;
    set_vec[pil_pkg::ID_FETCH] = fetch_trap_req && !trap_action_select;
    set_vec[pil_pkg::ID_GUARD] = guard_expiry_req && !guard_action_select;
    for (int i = 4; i < 16; i++) begin
      set_vec[i] = pil_pkg::level_request(4'(i), shared_level_select,
                                          src_int_req[i], src_alt_req);
    end
  end

  // latch next value
  always_comb begin
    next_pending_latch = pending_latch;
    if (wr_pend_low) begin
      next_pending_latch[7:0] = pending_latch[7:0] & sfr_wdata;
    end
    if (wr_pend_high) begin
      next_pending_latch[15:8] = pending_latch[15:8] & sfr_wdata;
    end
    if (accept_now) begin
      next_pending_latch[int_id] = 1'b0;
    end
    next_pending_latch = next_pending_latch | set_vec;
    next_pending_latch[1:0] = 2'b00;
  end

  // pending latches
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pending_latch <= pil_pkg::PEND_RST;
    end else begin
      pending_latch <= next_pending_latch;
    end
  end

  // master enable and its save stack
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      master_int_enable <= 1'b0;
      master_save_stack <= '0;
    end else if (accept_now) begin
      master_save_stack <= {master_save_stack[STACK_DEPTH-2:0], master_int_enable};
      master_int_enable <= 1'b0;
    end else if (return_from_int_instr) begin
      master_int_enable <= master_save_stack[0];
      master_save_stack <= {1'b0, master_save_stack[STACK_DEPTH-1:1]};
    end else if (sfr_wr && (sfr_addr == pil_pkg::ADDR_EN_LOW)) begin
      master_int_enable <= sfr_wdata[pil_pkg::MASTER_EN_BIT];
    end
  end

  // level enables
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      level_int_enable <= pil_pkg::EN_RST;
    end else if (sfr_wr && (sfr_addr == pil_pkg::ADDR_EN_LOW)) begin
      level_int_enable[7:4] <= sfr_wdata[7:4];
    end else if (sfr_wr && (sfr_addr == pil_pkg::ADDR_EN_HIGH)) begin
      level_int_enable[15:8] <= sfr_wdata;
    end
  end

  // shared level selector
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      shared_level_select <= pil_pkg::SEL_RST;
    end else if (sfr_wr && (sfr_addr == pil_pkg::ADDR_SEL)) begin
      shared_level_select <= sfr_wdata & 8'hC7;
    end
  end

  // fetch trap and guard action selects
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      trap_action_select  <= pil_pkg::GUARD_ACT_RST;
      guard_action_select <= pil_pkg::GUARD_ACT_RST;
    end else if (sfr_wr && (sfr_addr == pil_pkg::ADDR_GUARD)) begin
      trap_action_select  <= sfr_wdata[pil_pkg::GUARD_TRAP_BIT];
      guard_action_select <= sfr_wdata[pil_pkg::GUARD_EXP_BIT];
    end
  end

  // reset requests when action select picks reset
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      trap_reset_req  <= 1'b0;
      guard_reset_req <= 1'b0;
    end else begin
      trap_reset_req  <= fetch_trap_req && trap_action_select;
      guard_reset_req <= guard_expiry_req && guard_action_select;
    end
  end

  // effective requests into the encoder
  always_comb begin
    eff_req = 16'h0000;
    eff_req[pil_pkg::ID_SOFT]  = soft_trap_request || bad_opcode_trap;
    eff_req[pil_pkg::ID_FETCH] = pending_latch[pil_pkg::ID_FETCH];
    eff_req[pil_pkg::ID_GUARD] = pending_latch[pil_pkg::ID_GUARD];
    for (int i = 4; i < 16; i++) begin
      eff_req[i] = pending_latch[i] && level_int_enable[i] && master_int_enable && !accept_now;
    end
    eff_req[pil_pkg::ID_EXT0] = eff_req[pil_pkg::ID_EXT0] && ext0_pin_enable;
    if (accept_now) begin
      eff_req[int_id] = 1'b0;
    end
  end

  assign enc_bus.req = eff_req;

  // registered offer to the cpu
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      int_pending <= 1'b0;
      int_id      <= pil_pkg::ID_SOFT;
      int_vector  <= pil_pkg::VEC_RESET;
    end else begin
      int_pending <= enc_bus.valid;
      int_id      <= enc_bus.id;
      int_vector  <= enc_bus.vector;
    end
  end

  // register read data
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sfr_rdata <= 8'h00;
    end else begin
      case (sfr_addr)
        pil_pkg::ADDR_EN_LOW:    sfr_rdata <= {level_int_enable[7:4], 3'b000, master_int_enable};
        pil_pkg::ADDR_EN_HIGH:   sfr_rdata <= level_int_enable[15:8];
        pil_pkg::ADDR_PEND_LOW:  sfr_rdata <= pending_latch[7:0];
        pil_pkg::ADDR_PEND_HIGH: sfr_rdata <= pending_latch[15:8];
        pil_pkg::ADDR_SEL:       sfr_rdata <= shared_level_select;
        pil_pkg::ADDR_GUARD:     sfr_rdata <= {4'h0, guard_action_select, trap_action_select, 2'b00};
        default:                 sfr_rdata <= 8'h00;
      endcase
    end
  end

  // helpers read only by checks
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      accepted_id  <= pil_pkg::ID_SOFT;
      nmi_seen     <= 1'b0;
      enabled_seen <= 16'h0000;
    end else begin
      accepted_id  <= int_id;
      nmi_seen     <= (eff_req[3:0] != 4'h0);
      enabled_seen <= pending_latch & level_int_enable;
    end
  end

  chk_reset_clears: assert property (
    @(posedge ref_clk) srst |=> (pending_latch == 16'h0000) && !master_int_enable && (level_int_enable == 16'h0000))
    else $error("reset left latches or enables set");

  chk_accept_clears: assert property (
    @(posedge ref_clk) disable iff (srst)
    (accept_now && (int_id >= 4'h2) && !set_vec[int_id]) |=> !pending_latch[accepted_id])
    else $error("accepted latch not cleared");

  chk_sw_never_sets: assert property (
    @(posedge ref_clk) disable iff (srst)
    (wr_pend_low && (set_vec[7:0] == 8'h00))
      |=> ((pending_latch[7:0] & ~($past(pending_latch[7:0]) & $past(sfr_wdata))) == 8'h00))
    else $error("software write set a latch");

  chk_set_wins: assert property (
    @(posedge ref_clk) disable iff (srst)
    (set_vec != 16'h0000) |=> ((pending_latch & $past(set_vec)) == $past(set_vec)))
    else $error("request lost against clear");

  chk_master_save: assert property (
    @(posedge ref_clk) disable iff (srst)
    accept_now |=> !master_int_enable && (master_save_stack[0] == $past(master_int_enable)))
    else $error("master enable not saved and cleared");

  chk_master_restore: assert property (
    @(posedge ref_clk) disable iff (srst)
    (return_from_int_instr && !accept_now) |=> (master_int_enable == $past(master_save_stack[0])))
    else $error("master enable not restored");

  chk_mask_gate: assert property (
    @(posedge ref_clk) disable iff (srst)
    (int_pending && (int_id >= 4'h4)) |-> $past(master_int_enable) && $past(!int_accept))
    else $error("maskable offered while masked");

  chk_ext0_gate: assert property (
    @(posedge ref_clk) disable iff (srst)
    (int_pending && (int_id == 4'h4)) |-> $past(ext0_pin_enable) && $past(level_int_enable[4]))
    else $error("level four offered without pin enable");

  chk_nmi_first: assert property (
    @(posedge ref_clk) disable iff (srst)
    (int_pending && (int_id >= 4'h4)) |-> !nmi_seen)
    else $error("maskable offered over non-maskable");

  chk_vector_map: assert property (
    @(posedge ref_clk) disable iff (srst)
    int_pending |-> (int_vector == ((int_id == 4'h0) ? 16'hFFFC : (16'hFFFE - {11'h000, int_id, 1'b0}))))
    else $error("vector does not match source");

  chk_trap_route: assert property (
    @(posedge ref_clk) disable iff (srst)
    (fetch_trap_req && trap_action_select) |=> trap_reset_req ##1 !trap_reset_req || $past(fetch_trap_req))
    else $error("fetch trap not routed to reset");

  chk_shared_drop: assert property (
    @(posedge ref_clk) disable iff (srst)
    (!shared_level_select[0] && !src_int_req[15] && !pending_latch[15]) |=> !pending_latch[15])
    else $error("unselected source held in latch");

  chk_soft_offer: assert property (
    @(posedge ref_clk) disable iff (srst)
    ((soft_trap_request || bad_opcode_trap) && !accept_now)
      |=> int_pending && (int_id == 4'h0) && (int_vector == 16'hFFFC))
    else $error("soft trap not offered at its vector");

  chk_low_readback: assert property (
    @(posedge ref_clk) disable iff (srst)
    (sfr_addr == pil_pkg::ADDR_PEND_LOW) |=> (sfr_rdata == $past(pending_latch[7:0])))
    else $error("low latch byte not read back");

  chk_high_readback: assert property (
    @(posedge ref_clk) disable iff (srst)
    (sfr_addr == pil_pkg::ADDR_PEND_HIGH) |=> (sfr_rdata == $past(pending_latch[15:8])))
    else $error("high latch byte not read back");

  chk_high_clear: assert property (
    @(posedge ref_clk) disable iff (srst)
    (wr_pend_high && (set_vec[15:8] == 8'h00) && !accept_now)
      |=> (pending_latch[15:8] == ($past(pending_latch[15:8]) & $past(sfr_wdata))))
    else $error("high latch write not a pure clear");

  chk_master_write: assert property (
    @(posedge ref_clk) disable iff (srst)
    (sfr_wr && (sfr_addr == pil_pkg::ADDR_EN_LOW) && !accept_now && !return_from_int_instr)
      |=> (master_int_enable == $past(sfr_wdata[pil_pkg::MASTER_EN_BIT])))
    else $error("master enable write lost");

  chk_enable_write: assert property (
    @(posedge ref_clk) disable iff (srst)
    (sfr_wr && (sfr_addr == pil_pkg::ADDR_EN_HIGH)) |=> (level_int_enable[15:8] == $past(sfr_wdata)))
    else $error("level enable write lost");

  chk_trap_latch: assert property (
    @(posedge ref_clk) disable iff (srst)
    (fetch_trap_req && !trap_action_select) |=> pending_latch[pil_pkg::ID_FETCH] && !trap_reset_req)
    else $error("fetch trap not latched as interrupt");

  chk_guard_latch: assert property (
    @(posedge ref_clk) disable iff (srst)
    (guard_expiry_req && !guard_action_select) |=> pending_latch[pil_pkg::ID_GUARD] && !guard_reset_req)
    else $error("guard expiry not latched as interrupt");

  chk_guard_route: assert property (
    @(posedge ref_clk) disable iff (srst)
    (guard_expiry_req && guard_action_select) |=> guard_reset_req)
    else $error("guard expiry not routed to reset");

  chk_action_reset: assert property (
    @(posedge ref_clk) srst |=> trap_action_select && guard_action_select)
    else $error("action selects not set by reset");

  chk_alt_select: assert property (
    @(posedge ref_clk) disable iff (srst)
    (shared_level_select[pil_pkg::SEL_L8] && src_alt_req[0]) |=> pending_latch[8])
    else $error("selected alternate source not latched");

  chk_offer_enabled: assert property (
    @(posedge ref_clk) disable iff (srst)
    (int_pending && (int_id >= pil_pkg::ID_FIRST_MASK)) |-> enabled_seen[int_id])
    else $error("maskable offered without latch and enable");

endmodule : pil_latch_unit

// ===== pil_pkg.sv
// Purpose: constants, types and helpers of the prioritized interrupt latch unit
// Assumes: byte-wide special function register port
// Notes:   latch index equals source level id; ids 0 and 1 have no latch
package pil_pkg;

  typedef logic [3:0] pil_id_t;

  // register offsets
  localparam logic [7:0] ADDR_EN_LOW    = 8'h3A;
  localparam logic [7:0] ADDR_EN_HIGH   = 8'h3B;
  localparam logic [7:0] ADDR_PEND_LOW  = 8'h3C;
  localparam logic [7:0] ADDR_PEND_HIGH = 8'h3D;
  localparam logic [7:0] ADDR_SEL       = 8'h3E;
  localparam logic [7:0] ADDR_GUARD     = 8'h34;

  // field positions
  localparam int MASTER_EN_BIT  = 0;
  localparam int SEL_L8         = 7;
  localparam int SEL_L9         = 6;
  localparam int SEL_L13        = 2;
  localparam int SEL_L14        = 1;
  localparam int SEL_L15        = 0;
  localparam int GUARD_TRAP_BIT = 2;
  localparam int GUARD_EXP_BIT  = 3;

  // source ids
  localparam pil_id_t ID_SOFT        = 4'h0;
  localparam pil_id_t ID_FETCH       = 4'h2;
  localparam pil_id_t ID_GUARD       = 4'h3;
  localparam pil_id_t ID_EXT0        = 4'h4;
  localparam pil_id_t ID_FIRST_MASK  = 4'h4;

  // values after reset
  localparam logic [15:0] PEND_RST      = 16'h0000;
  localparam logic [15:0] EN_RST        = 16'h0000;
  localparam logic [7:0]  SEL_RST       = 8'h00;
  localparam logic        GUARD_ACT_RST = 1'b1;

  // vectors
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_SOFT  = 16'hFFFC;

  // vector of a source id
  function automatic logic [15:0] vector_of(input pil_id_t id);
    if (id == ID_SOFT) begin
      return VEC_SOFT;
    end
    return VEC_RESET - {11'h000, id, 1'b0};
  endfunction : vector_of

  // request of a level after the shared-level selector
  function automatic logic level_request(input pil_id_t    lvl,
                                         input logic [7:0] sel,
                                         input logic       int_req,
                                         input logic [4:0] alt);
    case (lvl)
      4'h8:    return sel[SEL_L8]  ? alt[0] : int_req;
      4'h9:    return sel[SEL_L9]  ? alt[1] : int_req;
      4'hD:    return sel[SEL_L13] ? alt[2] : int_req;
      4'hE:    return sel[SEL_L14] ? alt[3] : int_req;
      4'hF:    return sel[SEL_L15] ? alt[4] : int_req;
      default: return int_req;
    endcase
  endfunction : level_request

endpackage : pil_pkg

// ===== pil_prio_enc.sv
// Purpose: fixed priority selection of one effective request and its vector
// Assumes: lower id means higher priority
// Notes:   non-maskable ids 0, 2, 3 always rank above the maskable ids
`timescale 1ns/10ps
module pil_prio_enc (
  // encoder side of the carrier
  pil_enc_if.enc enc
);

  always_comb begin
    enc.valid  = 1'b0;
    enc.id     = pil_pkg::ID_SOFT;
    for (int i = 15; i >= 0; i--) begin
      if (enc.req[i]) begin
        enc.valid = 1'b1;
        enc.id    = 4'(i);
      end
    end
    enc.vector = pil_pkg::vector_of(enc.id);
  end

endmodule : pil_prio_enc

// ===== prioritized_interrupt_latch_unit_bench.sv
// Purpose: self-checking bench of the interrupt latch unit
// Assumes: inputs driven on the falling edge; fixed latencies of the unit
// Notes:   one task per scenario
`timescale 1ns/10ps
module prioritized_interrupt_latch_unit_bench;
  logic             ref_clk, srst, sfr_wr, int_accept, return_from_int_instr;
  logic [7:0]       sfr_addr, sfr_wdata, sfr_rdata;
  logic             soft_trap_request, bad_opcode_trap, fetch_trap_req, guard_expiry_req;
  logic             ext0_pin_enable, int_pending, trap_reset_req, guard_reset_req;
  logic [15:4]      src_int_req;
  logic [4:0]       src_alt_req;
  pil_pkg::pil_id_t int_id;
  logic [15:0]      int_vector, vec;
  int               fail_count = 0;
  int               check_count = 0;
  int               lv[5] = '{8, 9, 13, 14, 15};
  int               sb[5] = '{7, 6, 2, 1, 0};

  pil_latch_unit #(.STACK_DEPTH(8)) uut (.ref_clk(ref_clk), .srst(srst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .soft_trap_request(soft_trap_request), .bad_opcode_trap(bad_opcode_trap),
    .fetch_trap_req(fetch_trap_req), .guard_expiry_req(guard_expiry_req),
    .src_int_req(src_int_req), .src_alt_req(src_alt_req), .ext0_pin_enable(ext0_pin_enable),
    .int_accept(int_accept), .return_from_int_instr(return_from_int_instr),
    .int_pending(int_pending), .int_id(int_id), .int_vector(int_vector),
    .trap_reset_req(trap_reset_req), .guard_reset_req(guard_reset_req));

  pil_cpu_model cpu (.ref_clk(ref_clk), .int_pending(int_pending), .int_id(int_id),
    .int_vector(int_vector), .int_accept(int_accept), .return_from_int_instr(return_from_int_instr));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    sfr_addr = a;
    @(negedge ref_clk);
    check({8'h00, sfr_rdata}, {8'h00, exp});
  endtask : rdchk

  task automatic pulse(input logic [15:4] s, input logic [4:0] alt, input logic ft, input logic gd);
    @(negedge ref_clk);
    src_int_req = s;
    src_alt_req = alt;
    fetch_trap_req = ft;
    guard_expiry_req = gd;
    @(negedge ref_clk);
    src_int_req = 12'h000;
    src_alt_req = 5'h00;
    fetch_trap_req = 1'b0;
    guard_expiry_req = 1'b0;
  endtask : pulse

  task automatic offer(input logic p, input pil_pkg::pil_id_t id);
    check({15'h0000, int_pending}, {15'h0000, p});
    if (p) begin
      check({12'h000, int_id}, {12'h000, id});
      check(int_vector, (id == 4'h0) ? 16'hFFFC : 16'hFFFE - {11'h000, id, 1'b0});
    end
  endtask : offer

  task automatic clr();
    wr(8'h3C, 8'h0F);
    wr(8'h3D, 8'h00);
  endtask : clr

  task automatic t_reset();
    rdchk(8'h3A, 8'h00);
    rdchk(8'h3B, 8'h00);
    rdchk(8'h3C, 8'h00);
    rdchk(8'h3D, 8'h00);
    rdchk(8'h3E, 8'h00);
    rdchk(8'h34, 8'h0C);
    rdchk(8'h55, 8'h00);
    offer(1'b0, 4'h0);
    $display("done reset values");
  endtask : t_reset

  task automatic t_latch();
    pulse(12'hFFF, 5'h00, 1'b0, 1'b0);
    rdchk(8'h3C, 8'hF0);
    rdchk(8'h3D, 8'hFF);
    offer(1'b0, 4'h0);
    wr(8'h3C, 8'hCF);
    rdchk(8'h3C, 8'hC0);
    wr(8'h3D, 8'h00);
    wr(8'h3D, 8'hFF);
    rdchk(8'h3D, 8'h00);
    @(negedge ref_clk);
    sfr_addr = 8'h3C;
    sfr_wdata = 8'h0F;
    sfr_wr = 1'b1;
    src_int_req = 12'h004;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
    src_int_req = 12'h000;
    rdchk(8'h3C, 8'h40);
    clr();
    $display("done latch access");
  endtask : t_latch

  task automatic t_prio();
    wr(8'h3A, 8'hF0);
    wr(8'h3B, 8'hFF);
    wr(8'h3A, 8'hF1);
    pulse(12'h102, 5'h00, 1'b0, 1'b0);
    @(negedge ref_clk);
    offer(1'b1, 4'h5);
    cpu.take(0, vec);
    check(vec, 16'hFFF4);
    offer(1'b0, 4'h0);
    rdchk(8'h3C, 8'h00);
    rdchk(8'h3A, 8'hF0);
    cpu.give_back();
    @(negedge ref_clk);
    offer(1'b1, 4'hC);
    cpu.take(3, vec);
    check(vec, 16'hFFE6);
    rdchk(8'h3D, 8'h00);
    cpu.give_back();
    $display("done priority and accept");
  endtask : t_prio

  task automatic t_mask();
    pulse(12'h001, 5'h00, 1'b0, 1'b0);
    @(negedge ref_clk);
    offer(1'b0, 4'h0);
    ext0_pin_enable = 1'b1;
    @(negedge ref_clk);
    offer(1'b1, 4'h4);
    wr(8'h3A, 8'hF0);
    @(negedge ref_clk);
    offer(1'b0, 4'h0);
    clr();
    $display("done masking");
  endtask : t_mask

  task automatic t_nmi();
    pulse(12'h000, 5'h00, 1'b1, 1'b1);
    check({14'h0000, trap_reset_req, guard_reset_req}, 16'h0003);
    rdchk(8'h3C, 8'h00);
    wr(8'h34, 8'h00);
    pulse(12'h000, 5'h00, 1'b1, 1'b1);
    @(negedge ref_clk);
    offer(1'b1, 4'h2);
    rdchk(8'h3C, 8'h0C);
    soft_trap_request = 1'b1;
    @(negedge ref_clk);
    offer(1'b1, 4'h0);
    soft_trap_request = 1'b0;
    bad_opcode_trap = 1'b1;
    @(negedge ref_clk);
    @(negedge ref_clk);
    offer(1'b1, 4'h0);
    bad_opcode_trap = 1'b0;
    @(negedge ref_clk);
    @(negedge ref_clk);
    cpu.take(0, vec);
    check(vec, 16'hFFFA);
    offer(1'b1, 4'h3);
    cpu.take(0, vec);
    check(vec, 16'hFFF8);
    cpu.give_back();
    cpu.give_back();
    rdchk(8'h3C, 8'h00);
    $display("done non-maskable");
  endtask : t_nmi

  task automatic t_shared();
    for (int i = 0; i < 5; i++) begin
      wr(8'h3E, 8'h00);
      pulse(12'h000, 5'h01 << i, 1'b0, 1'b0);
      rdchk(8'h3D, 8'h00);
      pulse(12'h001 << (lv[i] - 4), 5'h00, 1'b0, 1'b0);
      rdchk(8'h3D, 8'h01 << (lv[i] - 8));
      clr();
      wr(8'h3E, 8'h01 << sb[i]);
      pulse(12'h001 << (lv[i] - 4), 5'h00, 1'b0, 1'b0);
      rdchk(8'h3D, 8'h00);
      pulse(12'h000, 5'h01 << i, 1'b0, 1'b0);
      rdchk(8'h3D, 8'h01 << (lv[i] - 8));
      clr();
    end
    $display("done shared levels");
  endtask : t_shared

  task automatic t_midreset();
    wr(8'h3A, 8'hF1);
    wr(8'h3E, 8'hC7);
    pulse(12'hFFF, 5'h00, 1'b1, 1'b0);
    rdchk(8'h3E, 8'hC7);
    rdchk(8'h3C, 8'hF4);
    rdchk(8'h3D, 8'h1C);
    offer(1'b1, 4'h2);
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    offer(1'b0, 4'h0);
    check({14'h0000, trap_reset_req, guard_reset_req}, 16'h0000);
    t_reset();
    $display("done reset in mid-run");
  endtask : t_midreset

  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    give_verdict();
  end

  initial begin
    srst = 1'b1;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_wdata = 8'h00;
    soft_trap_request = 1'b0;
    bad_opcode_trap = 1'b0;
    fetch_trap_req = 1'b0;
    guard_expiry_req = 1'b0;
    src_int_req = 12'h000;
    src_alt_req = 5'h00;
    ext0_pin_enable = 1'b0;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    srst = 1'b0;
    t_reset();
    t_latch();
    t_prio();
    t_mask();
    t_nmi();
    t_shared();
    t_midreset();
    give_verdict();
  end
endmodule : prioritized_interrupt_latch_unit_bench
